// ==== pkg/rss_map.svh ====
// Register map, field positions and timing counts of the reset source supervisor
`ifndef RSS_MAP_SVH
`define RSS_MAP_SVH
`define RSS_PRC_IDX        8'hAF
`define RSS_PRC_ADDR       12'h2BC
`define RSS_STAT_ADDR      12'h2C0
`define RSS_CTRL_ADDR      12'h2C4
`define RSS_PRC_WDT_BIT    2
`define RSS_PRC_LVD_BIT    0
`define RSS_PRC_RESET      8'h01
`define RSS_PRC_WMASK      8'h05
`define RSS_DROP_EXP       10
`define RSS_HOLD_EXP       17
`endif

// ==== pkg/rss_pkg.sv ====
// Types of the reset source supervisor
package rss_pkg;
  typedef enum logic [1:0] {
    RSS_RUN  = 2'b00,
    RSS_IDLE = 2'b01,
    RSS_PD   = 2'b10
  } rss_mode_t;
  typedef enum logic [1:0] {
    RSS_OK    = 2'b00,
    RSS_DROP  = 2'b01,
    RSS_LOW   = 2'b10,
    RSS_HOLD  = 2'b11
  } rss_lvd_t;
endpackage : rss_pkg

// ==== design/rss_lvd_filter.sv ====
// One low-voltage detector channel: synchroniser, drop-down width filter and release hold
`timescale 1ns/10ps
`default_nettype none
module rss_lvd_filter #(
  parameter int DROP_CYC = 1024,
  parameter int HOLD_CYC = 131072,
  // Set on the supply channel: reset release is then held like a recovery
  parameter bit START_HELD = 1'b0
) (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic arm,
  input  wire logic low_async,
  output logic      rst_out
);
  localparam int CW = $clog2(HOLD_CYC + 1);
  initial begin
    if (DROP_CYC < 1 || HOLD_CYC < 1 || DROP_CYC > HOLD_CYC)
      $error("rss_lvd_filter: bad counts");
  end
  logic [2:0]        sync_q;
  logic [2:0]        sync_d;
  logic              low_q;
  logic              low_d;
  rss_pkg::rss_lvd_t st_q;
  rss_pkg::rss_lvd_t st_d;
  logic [CW-1:0]     cnt_q;
  logic [CW-1:0]     cnt_d;
  logic              rst_q;
  logic              rst_d;
  always_comb begin
    sync_d = {sync_q[1:0], low_async};
    low_d  = (sync_q[1] == sync_q[2]) ? sync_q[2] : low_q;
    st_d   = st_q;
    cnt_d  = cnt_q;
    case (st_q)
      rss_pkg::RSS_OK: begin
        if (low_q && arm) begin
          st_d  = rss_pkg::RSS_DROP;
          cnt_d = CW'(1);
        end
      end
      rss_pkg::RSS_DROP: begin
        // Drop must persist for full width
        if (!low_q || !arm) begin
          st_d = rss_pkg::RSS_OK;
        end else if (cnt_q >= CW'(DROP_CYC)) begin
          st_d = rss_pkg::RSS_LOW;
        end else begin
          cnt_d = cnt_q + CW'(1);
        end
      end
      rss_pkg::RSS_LOW: begin
        if (!low_q) begin
          st_d  = rss_pkg::RSS_HOLD;
          cnt_d = CW'(1);
        end
      end
      rss_pkg::RSS_HOLD: begin
        // Hold after recovery, restart on new sag
        if (low_q) begin
          st_d = rss_pkg::RSS_LOW;
        end else if (cnt_q >= CW'(HOLD_CYC)) begin
          st_d = rss_pkg::RSS_OK;
        end else begin
          cnt_d = cnt_q + CW'(1);
        end
      end
      default: st_d = rss_pkg::RSS_OK;
    endcase
    rst_d = (st_d == rss_pkg::RSS_LOW) || (st_d == rss_pkg::RSS_HOLD);
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync_q <= 3'h0;
      low_q  <= 1'b0;
      st_q   <= START_HELD ? rss_pkg::RSS_HOLD : rss_pkg::RSS_OK;
      cnt_q  <= START_HELD ? CW'(1) : CW'(0);
      rst_q  <= START_HELD;
    end else begin
      sync_q <= sync_d;
      low_q  <= low_d;
      st_q   <= st_d;
      cnt_q  <= cnt_d;
      rst_q  <= rst_d;
    end
  end
  assign rst_out = rst_q;
endmodule : rss_lvd_filter
`default_nettype wire

// ==== design/rss_supervisor.sv ====
// Reset source supervisor: reset merge, supply filters, power-on hold and control register
//
// Chosen here: the APB register port.
`timescale 1ns/10ps
`default_nettype none
`include "rss_map.svh"
// Overview of operation
// - Merge hardware, watchdog, resume and bus-reset causes into system reset.
// - Power-on reset is asserted from first power and resets whole chip.
// - Power-on reset holds 2^17 clocks after supply passes threshold.
// - Supply supervisor stays active in normal, idle and power-down.
// - Supply reset after 2^10 low clocks; shares signal with power-on reset.
// - Supply reset held 2^17 clocks after supply recovers.
// - Idle watchdog enable, bit 2, resets to 0; 1 runs watchdog in idle.
// - Core detector enable, bit 0, resets to 1; arms core detector in power-down.
// - Control fields reset on hardware, bus or resume reset, not watchdog.
// - Core rail reset after 2^10 low clocks.
// - Core rail reset held 2^17 clocks after recovery.
// - IO rail sag drives a whole-chip reset.
// - IO rail reset after 2^10 low clocks, released 2^17 after recovery.
// - Core and peripherals run from the 12 MHz system clock.
// - Wake-up timer runs from its own 32 kHz clock, outside this block.
// - Watchdog overflow raises the watchdog reset source.
// - Resume reset reinitialises control fields and restarts fetch at zero.
// - Bus reset reinitialises some registers and restarts at zero.
module rss_supervisor #(
  parameter int DROP_CYC = 1 << `RSS_DROP_EXP,
  parameter int HOLD_CYC = 1 << `RSS_HOLD_EXP
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        supply_low,
  input  wire logic        core_low,
  input  wire logic        io_low,
  input  wire logic        ext_reset_n,
  input  wire logic        watchdog_overflow,
  input  wire logic        resume_event,
  input  wire logic        usb_bus_reset,
  input  wire logic [1:0]  cpu_mode,
  output logic             system_reset,
  output logic             hw_reset,
  output logic             field_reset,
  output logic             idle_watchdog_enable,
  output logic             watchdog_run
);
  initial begin
    if (DROP_CYC < 1 || HOLD_CYC < DROP_CYC)
      $error("rss_supervisor: bad counts");
  end
  logic            sup_rst;
  logic            core_rst;
  logic            io_rst;
  logic            core_arm;
  logic [2:0]      ext_q;
  logic [2:0]      ext_d;
  logic            ext_rst_q;
  logic            ext_rst_d;
  logic [2:0]      src_q;
  logic [2:0]      src_d;
  logic [7:0]      prc_q;
  logic [7:0]      prc_d;
  logic [7:0]      cause_q;
  logic [7:0]      cause_d;
  logic            sys_q;
  logic            sys_d;
  logic            hw_q;
  logic            hw_d;
  logic            fld_q;
  logic            fld_d;
  logic [31:0]     rdata_q;
  logic [31:0]     rdata_d;
  logic            wr;
  logic            rd;
  logic            hit;
  rss_pkg::rss_mode_t mode;
  assign mode = rss_pkg::rss_mode_t'(cpu_mode);
  assign core_arm = (mode != rss_pkg::RSS_PD) || prc_q[`RSS_PRC_LVD_BIT];
  // supply channel leaves reset in its hold phase
  rss_lvd_filter #(.DROP_CYC(DROP_CYC), .HOLD_CYC(HOLD_CYC), .START_HELD(1'b1)) u_supply (
    .pclk      (pclk),
    .presetn   (presetn),
    .arm       (1'b1),
    .low_async (supply_low),
    .rst_out   (sup_rst)
  );
  rss_lvd_filter #(.DROP_CYC(DROP_CYC), .HOLD_CYC(HOLD_CYC)) u_core (
    .pclk      (pclk),
    .presetn   (presetn),
    .arm       (core_arm),
    .low_async (core_low),
    .rst_out   (core_rst)
  );
  rss_lvd_filter #(.DROP_CYC(DROP_CYC), .HOLD_CYC(HOLD_CYC)) u_io (
    .pclk      (pclk),
    .presetn   (presetn),
    .arm       (1'b1),
    .low_async (io_low),
    .rst_out   (io_rst)
  );
  assign wr  = psel && penable && pwrite;
  assign rd  = psel && !penable && !pwrite;
  assign hit = (paddr == `RSS_PRC_ADDR) || (paddr == `RSS_STAT_ADDR);
  always_comb begin
    // Pin reset synchronised, second and third agree
    ext_d     = {ext_q[1:0], !ext_reset_n};
    ext_rst_d = (ext_q[1] == ext_q[2]) ? ext_q[2] : ext_rst_q;
    // Same-clock pulses registered for clean merge
    src_d = {usb_bus_reset, resume_event, watchdog_overflow};
    // power-on hold via shared supply filter
    // io rail sag resets whole chip
    hw_d  = sup_rst || core_rst || io_rst || ext_rst_q;
    fld_d = hw_d || src_q[1] || src_q[2];
    sys_d = hw_d || src_q[0] || src_q[1] || src_q[2];
    prc_d = prc_q;
    if (fld_q) begin
      prc_d = `RSS_PRC_RESET;
    end else if (wr && paddr == `RSS_PRC_ADDR) begin
      prc_d = pwdata[7:0] & `RSS_PRC_WMASK;
    end
    // Cause flags sticky; set wins over the clear
    cause_d = cause_q;
    if (wr && paddr == `RSS_STAT_ADDR) begin
      cause_d = cause_q & ~pwdata[7:0];
    end
    cause_d = cause_d | {2'b00, io_rst, core_rst, src_q[2], src_q[1], src_q[0], sup_rst};
    rdata_d = rdata_q;
    if (rd) begin
      case (paddr)
        `RSS_PRC_ADDR:  rdata_d = {24'h000000, prc_q};
        `RSS_STAT_ADDR: rdata_d = {24'h000000, cause_q};
        default:        rdata_d = 32'h00000000;
      endcase
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ext_q     <= 3'h0;
      ext_rst_q <= 1'b0;
      src_q     <= 3'h0;
      prc_q     <= `RSS_PRC_RESET;
      cause_q   <= 8'h01;
      sys_q     <= 1'b1;
      hw_q      <= 1'b1;
      fld_q     <= 1'b1;
      rdata_q   <= 32'h00000000;
    end else begin
      ext_q     <= ext_d;
      ext_rst_q <= ext_rst_d;
      src_q     <= src_d;
      prc_q     <= prc_d;
      cause_q   <= cause_d;
      sys_q     <= sys_d;
      hw_q      <= hw_d;
      fld_q     <= fld_d;
      rdata_q   <= rdata_d;
    end
  end
  // all logic on the 12 MHz system clock
  assign system_reset         = sys_q;
  assign hw_reset             = hw_q;
  assign field_reset          = fld_q;
  assign idle_watchdog_enable = prc_q[`RSS_PRC_WDT_BIT];
  assign watchdog_run = (mode == rss_pkg::RSS_RUN) ||
                        ((mode == rss_pkg::RSS_IDLE) && prc_q[`RSS_PRC_WDT_BIT]);
  // Zero-wait; read data registered in setup
  assign prdata  = rdata_q;
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !hit;
endmodule : rss_supervisor
`default_nettype wire

// ==== sim/rss_supervisor_chk.sv ====
// Port checker of the reset source supervisor
`timescale 1ns/10ps
`default_nettype none
module rss_supervisor_chk #(
  parameter int DROP_CYC = 1024,
  parameter int HOLD_CYC = 131072
) (
  input wire logic       pclk,
  input wire logic       presetn,
  input wire logic       supply_low,
  input wire logic       ext_reset_n,
  input wire logic       watchdog_overflow,
  input wire logic       resume_event,
  input wire logic       usb_bus_reset,
  input wire logic [1:0] cpu_mode,
  input wire logic       system_reset,
  input wire logic       hw_reset,
  input wire logic       field_reset,
  input wire logic       idle_watchdog_enable,
  input wire logic       watchdog_run
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Run length of supply low; slack of ten covers sync and output stages
  logic [7:0] low_cnt_q;
  logic [7:0] low_cnt_d;
  always_comb begin
    low_cnt_d = !supply_low ? 8'h00 : (&low_cnt_q ? low_cnt_q : low_cnt_q + 8'h01);
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) low_cnt_q <= 8'h00;
    else low_cnt_q <= low_cnt_d;
  end
  property p_wdt_src; watchdog_overflow |-> ##2 system_reset; endproperty
  a_wdt_src: assert property (p_wdt_src) else $error("watchdog cause lost");
  property p_rsm_src; resume_event |-> ##2 system_reset; endproperty
  a_rsm_src: assert property (p_rsm_src) else $error("resume cause lost");
  property p_usb_fld; usb_bus_reset |-> ##[1:3] field_reset; endproperty
  a_usb_fld: assert property (p_usb_fld) else $error("bus reset no reinit");
  property p_wdt_keep; watchdog_overflow && !field_reset |=> $stable(idle_watchdog_enable)[*3]; endproperty
  a_wdt_keep: assert property (p_wdt_keep) else $error("watchdog cleared field");
  property p_run; watchdog_run == (cpu_mode == 2'h0 || cpu_mode == 2'h1 && idle_watchdog_enable); endproperty
  a_run: assert property (p_run) else $error("watchdog run wrong");
  property p_drop; low_cnt_q == DROP_CYC + 10 |-> system_reset; endproperty
  a_drop: assert property (p_drop) else $error("supply reset late");
  property p_hold; $fell(supply_low) && system_reset |-> system_reset[*8]; endproperty
  a_hold: assert property (p_hold) else $error("supply hold short");
  property p_ext; !ext_reset_n |-> ##[1:5] hw_reset; endproperty
  a_ext: assert property (p_ext) else $error("pin reset lost");
  property p_fld; field_reset |=> !idle_watchdog_enable; endproperty
  a_fld: assert property (p_fld) else $error("field not reinit");
endmodule : rss_supervisor_chk
bind rss_supervisor rss_supervisor_chk #(.DROP_CYC(DROP_CYC), .HOLD_CYC(HOLD_CYC)) chk_i (
  .pclk(pclk), .presetn(presetn), .supply_low(supply_low), .ext_reset_n(ext_reset_n),
  .watchdog_overflow(watchdog_overflow), .resume_event(resume_event),
  .usb_bus_reset(usb_bus_reset), .cpu_mode(cpu_mode), .system_reset(system_reset),
  .hw_reset(hw_reset), .field_reset(field_reset),
  .idle_watchdog_enable(idle_watchdog_enable), .watchdog_run(watchdog_run));
`default_nettype wire

// ==== sim/rss_supervisor_tb.sv ====
// Self-checking testbench of the reset source supervisor
`timescale 1ns/10ps
`default_nettype none
`include "rss_map.svh"
module rss_supervisor_tb;
  localparam int DROP_CYC = 4;
  localparam int HOLD_CYC = 16;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, slv;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [2:0]  low, ev;
  logic [1:0]  cpu_mode;
  logic        ext_reset_n, system_reset, hw_reset, field_reset, iwe, wrun;
  int          errors, cmp_count, t;
  rss_supervisor #(.DROP_CYC(DROP_CYC), .HOLD_CYC(HOLD_CYC)) rss_supervisor_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .supply_low(low[0]), .core_low(low[1]), .io_low(low[2]), .ext_reset_n(ext_reset_n),
    .watchdog_overflow(ev[0]), .resume_event(ev[1]), .usb_bus_reset(ev[2]),
    .cpu_mode(cpu_mode), .system_reset(system_reset), .hw_reset(hw_reset),
    .field_reset(field_reset), .idle_watchdog_enable(iwe), .watchdog_run(wrun));
  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end
  task automatic end_of_test();
    $display("errors %0d compares %0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : end_of_test
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check
  // One transfer; the request stands until pready is seen high
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      errors++;
      end_of_test();
    end
    rd = prdata;
    slv = pslverr;
    {psel, penable} <= 2'b00;
  endtask : apb
  task automatic rdchk(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    check(rd, e);
  endtask : rdchk
  task automatic wait_idle(input int lim, output int c);
    c = 0;
    while (system_reset !== 1'b0) begin
      @(posedge pclk);
      c++;
      if (c > lim) begin
        errors++;
        end_of_test();
      end
    end
  endtask : wait_idle
  task automatic pulse(input int k);
    @(posedge pclk);
    ev[k] <= 1'b1;
    @(posedge pclk);
    ev[k] <= 1'b0;
    repeat (6) @(posedge pclk);
  endtask : pulse
  // Rail r low for len cycles in mode m; a short sag must be filtered out
  task automatic sag(input int r, input int len, input logic [1:0] m, input logic hit);
    t = 0;
    @(posedge pclk);
    cpu_mode <= m;
    low[r] <= 1'b1;
    for (int i = 0; i < len + 12; i++) begin
      @(posedge pclk);
      if (i == len - 1) low[r] <= 1'b0;
      if (system_reset === 1'b1 && t == 0) t = i + 1;
    end
    cpu_mode <= 2'h0;
    check(t != 0, hit);
    if (hit) begin
      check(t >= DROP_CYC, 1'b1);
      wait_idle(HOLD_CYC + 20, t);
      check(t + 12 >= HOLD_CYC && t + 12 <= HOLD_CYC + 10, 1'b1);
      rdchk(`RSS_PRC_ADDR, 32'h1);
    end
  endtask : sag
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata, low, ev, cpu_mode} = '0;
    ext_reset_n = 1'b1;
    errors = 0;
    cmp_count = 0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    wait_idle(HOLD_CYC + 20, t);
    check(t >= HOLD_CYC && t <= HOLD_CYC + 10, 1'b1);
    rdchk(`RSS_PRC_ADDR, 32'h1);
    check(iwe, 1'b0);
    apb(1'b1, `RSS_PRC_ADDR, 32'hFF);
    rdchk(`RSS_PRC_ADDR, 32'h5);
    rdchk(`RSS_CTRL_ADDR, 32'h0);
    check(slv, 1'b1);
    pulse(0);
    rdchk(`RSS_PRC_ADDR, 32'h5);
    apb(1'b0, `RSS_STAT_ADDR, 32'h0);
    check(rd[1], 1'b1);
    apb(1'b1, `RSS_STAT_ADDR, 32'hFF);
    rdchk(`RSS_STAT_ADDR, 32'h0);
    pulse(2);
    rdchk(`RSS_PRC_ADDR, 32'h1);
    apb(1'b1, `RSS_PRC_ADDR, 32'h5);
    pulse(1);
    rdchk(`RSS_PRC_ADDR, 32'h1);
    sag(0, 2, 2'h1, 1'b0);
    sag(0, DROP_CYC + 12, 2'h1, 1'b1);
    sag(0, DROP_CYC + 12, 2'h2, 1'b1);
    apb(1'b1, `RSS_PRC_ADDR, 32'h0);
    sag(1, DROP_CYC + 12, 2'h2, 1'b0);
    sag(1, DROP_CYC + 12, 2'h0, 1'b1);
    sag(2, 2, 2'h0, 1'b0);
    sag(2, DROP_CYC + 12, 2'h0, 1'b1);
    apb(1'b1, `RSS_PRC_ADDR, 32'h5);
    ext_reset_n <= 1'b0;
    repeat (4) @(posedge pclk);
    ext_reset_n <= 1'b1;
    repeat (2) @(posedge pclk);
    check(hw_reset, 1'b1);
    repeat (2) @(posedge pclk);
    check(system_reset, 1'b1);
    wait_idle(20, t);
    rdchk(`RSS_PRC_ADDR, 32'h1);
    end_of_test();
  end
endmodule : rss_supervisor_tb
`default_nettype wire
